// file: rtl/iosd_defs.vh
// constants for the io status display register bank
`ifndef IOSD_DEFS_VH
`define IOSD_DEFS_VH

// ==========================================
// register indices (byte address = 4 * index)
`define IOSD_IDX_COND_MET     16'h2217
`define IOSD_IDX_FLAG_STAT    16'h2218
`define IOSD_IDX_TERM_STAT    16'h2219
`define IOSD_IDX_ACTIVE_SET   16'h221A
`define IOSD_IDX_AIN_A_PRE    16'h221B
`define IOSD_IDX_AIN_A_POST   16'h221C
`define IOSD_IDX_AIN_B_PRE    16'h221D
`define IOSD_IDX_AIN_B_POST   16'h221E
`define IOSD_IDX_AOUT_A_PRE   16'h2221
`define IOSD_IDX_FLAG_CFG0    16'h2300
`define IOSD_IDX_EDIT_SET     16'h2308
`define IOSD_IDX_SET_CTRL     16'h2309

// ==========================================
// reset values
`define IOSD_RST_STATUS       16'h0000
`define IOSD_RST_CFG          18'h00000
`define IOSD_RST_SET          3'h0
`define IOSD_RST_EDIT_SET     3'h1

// ==========================================
// display limits in 0.1 percent units
`define IOSD_LIM_PRE          16'sh03E8
`define IOSD_LIM_POST         16'sh0FA0

// ==========================================
// flag configuration word fields
`define IOSD_CFG_MASK_LSB     0
`define IOSD_CFG_MASK_MSB     7
`define IOSD_CFG_INV_LSB      8
`define IOSD_CFG_INV_MSB      15
`define IOSD_CFG_MODE_OR      16
`define IOSD_CFG_INV_OUT      17
`define IOSD_CFG_W            18

// ==========================================
// set control fields and edit set blocked bit
`define IOSD_SC_BASE_LSB      0
`define IOSD_SC_BASE_MSB      2
`define IOSD_SC_AUTO_EN       3
`define IOSD_SC_TRIG_LSB      4
`define IOSD_SC_TRIG_MSB      6
`define IOSD_SC_TGT_LSB       8
`define IOSD_SC_TGT_MSB       10
`define IOSD_ES_BLOCKED       8

`endif

// file: rtl/iosd_flag_logic.v
// first logic step for one output flag
`timescale 1ns/1ps
`include "iosd_defs.vh"

module iosd_flag_logic (
  input  wire [7:0]               cond_i,
  input  wire [`IOSD_CFG_W-1:0]   cfg_i,
  output wire                     flag_o
);
  wire [7:0] mask;
  wire [7:0] terms;
  wire       and_res;
  wire       or_res;
  wire       raw;

  assign mask  = cfg_i[`IOSD_CFG_MASK_MSB:`IOSD_CFG_MASK_LSB];
  // each selected condition may be inverted before linking
  assign terms = (cond_i ^ cfg_i[`IOSD_CFG_INV_MSB:`IOSD_CFG_INV_LSB]) & mask;
  // an empty selection never sets the raw result, even in and-mode; output inversion still applies
  assign and_res = (mask != 8'h00) && (terms == mask);
  assign or_res  = |terms;
  assign raw     = cfg_i[`IOSD_CFG_MODE_OR] ? or_res : and_res;
  assign flag_o  = raw ^ cfg_i[`IOSD_CFG_INV_OUT];
endmodule

// file: rtl/iosd_status_bank.v
// io status display register bank with flag logic and parameter sets
// What this block does
// R1 - condition register bit n shows selected condition n met, before linking
// R2 - several met conditions read as the sum of their power-of-two weights
// R3 - eight output flags shown, bit n for flag n after logic step one
// R4 - logic step one links conditions per flag logic parameters of active set
// R5 - terminal bits: out one, out two, relay one, relay two, internal a-d
// R6 - eight parameter sets; active set number shown in its register
// R7 - active set may switch by itself from a programmed flag trigger
// R8 - host edits a non-active set without disturbing the active one
// R9 - input one before gain shown signed, -100 to 100 percent, 0.1 steps
// R10 - input one after gain shown in 0.1 steps, limited to +-400 percent
// R11 - input two before gain shown signed, -100 to 100 percent, 0.1 steps
// R12 - input two after gain shown in 0.1 steps, limited to +-400 percent
// R13 - output one before gain shown signed, -400 to 400 percent, 0.1 steps
// R14 - writes to display registers ignored; displays track live state
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "iosd_defs.vh"

module iosd_status_bank (
  input  wire        clk_i,
  input  wire        rst_i,
  // classic wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [17:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  // live state
  input  wire [7:0]  cond_met_i,
  input  wire [15:0] analog_input_one_pre_i,
  input  wire [15:0] analog_input_one_post_i,
  input  wire [15:0] analog_input_two_pre_i,
  input  wire [15:0] analog_input_two_post_i,
  input  wire [15:0] analog_output_one_pre_i,
  // terminals
  output wire        digital_output_one_o,
  output wire        digital_output_two_o,
  output wire        relay_one_o,
  output wire        relay_two_o,
  output wire        internal_output_a_o,
  output wire        internal_output_b_o,
  output wire        internal_output_c_o,
  output wire        internal_output_d_o,
  output wire [2:0]  active_set_o
);

  // ==========================================
  // helper: saturate a signed value to +-lim
  function [15:0] sat;
    input [15:0] v;
    input [15:0] lim;
    reg signed [15:0] sv;
    reg signed [15:0] sl;
    begin
      sv = v;
      sl = lim;
      if (sv > sl) begin
        sat = lim;
      end else if (sv < -sl) begin
        sat = -lim;
      end else begin
        sat = v;
      end
    end
  endfunction

  // ==========================================
  // status registers
  reg  [7:0]  cond_q;
  reg  [7:0]  flag_q;
  reg  [7:0]  term_q;
  reg  [2:0]  active_q;
  reg  [15:0] ain_a_pre_q;
  reg  [15:0] ain_a_post_q;
  reg  [15:0] ain_b_pre_q;
  reg  [15:0] ain_b_post_q;
  reg  [15:0] aout_a_pre_q;

  // ==========================================
  // configuration: 8 sets of 8 flag words
  reg  [`IOSD_CFG_W-1:0] cfg_mem [0:63];
  reg  [2:0]             edit_set_q;
  reg  [2:0]             base_set_q;
  reg                    auto_en_q;
  reg  [2:0]             trig_flag_q;
  reg  [2:0]             tgt_set_q;

  // ==========================================
  // bus signals
  reg         ack_q;
  reg  [31:0] dat_q;
  wire        req;
  wire [15:0] idx;
  wire        wr;
  wire        cfg_hit;
  wire [2:0]  cfg_flag;
  wire        edit_blocked;
  wire [7:0]  flag_d;
  reg  [2:0]  active_d;
  reg  [31:0] rd_d;

  assign req      = cyc_i & stb_i & ~ack_q;
  assign idx      = adr_i[17:2];
  assign wr       = req & we_i;
  assign cfg_hit  = ({idx[15:3], 3'b000} == `IOSD_IDX_FLAG_CFG0);
  assign cfg_flag = idx[2:0];
  assign edit_blocked = (edit_set_q == active_q);
  assign ack_o    = ack_q;
  assign dat_o    = dat_q;

  // ==========================================
  // first logic step, one instance per flag
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      // a genvar cannot be part-selected, so its low bits go through a localparam
      localparam [2:0] FLAG_IDX = g;
      iosd_flag_logic u_flag (
        .cond_i (cond_q),
        .cfg_i  (cfg_mem[{active_q, FLAG_IDX}]), // [R4]
        .flag_o (flag_d[g])
      );
    end
  endgenerate

  // ==========================================
  // autonomous set switching
  // while the trigger flag is set the target set governs, else the base set
  always @* begin
    if (auto_en_q && flag_q[trig_flag_q]) begin
      active_d = tgt_set_q; // [R7]
    end else begin
      active_d = base_set_q;
    end
  end

  // ==========================================
  // live status capture; conditions and analog values one cycle behind the inputs, flags two, terminals three
  always @(posedge clk_i) begin
    if (rst_i) begin
      cond_q       <= 8'h00;
      flag_q       <= 8'h00;
      term_q       <= 8'h00;
      active_q     <= `IOSD_RST_SET;
      ain_a_pre_q  <= `IOSD_RST_STATUS;
      ain_a_post_q <= `IOSD_RST_STATUS;
      ain_b_pre_q  <= `IOSD_RST_STATUS;
      ain_b_post_q <= `IOSD_RST_STATUS;
      aout_a_pre_q <= `IOSD_RST_STATUS;
    end else begin
      cond_q       <= cond_met_i; // [R1] [R2]
      flag_q       <= flag_d; // [R3]
      // the second logic step is not modelled: terminal n follows flag n
      term_q       <= flag_q; // [R5]
      active_q     <= active_d; // [R6]
      ain_a_pre_q  <= sat(analog_input_one_pre_i, `IOSD_LIM_PRE); // [R9]
      ain_a_post_q <= sat(analog_input_one_post_i, `IOSD_LIM_POST); // [R10]
      ain_b_pre_q  <= sat(analog_input_two_pre_i, `IOSD_LIM_PRE); // [R11]
      ain_b_post_q <= sat(analog_input_two_post_i, `IOSD_LIM_POST); // [R12]
      aout_a_pre_q <= sat(analog_output_one_pre_i, `IOSD_LIM_POST); // [R13]
    end
  end

  assign digital_output_one_o = term_q[0];
  assign digital_output_two_o = term_q[1];
  assign relay_one_o          = term_q[2];
  assign relay_two_o          = term_q[3];
  assign internal_output_a_o  = term_q[4];
  assign internal_output_b_o  = term_q[5];
  assign internal_output_c_o  = term_q[6];
  assign internal_output_d_o  = term_q[7];
  assign active_set_o         = active_q;

  // ==========================================
  // configuration writes
  // edits land in the edit set only; an edit aimed at the set now in use
  // is dropped so a running drive never sees a half-written configuration
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 64; i = i + 1) begin
        cfg_mem[i] <= `IOSD_RST_CFG;
      end
    end else if (wr && cfg_hit && !edit_blocked) begin // [R8]
      if (sel_i[0]) begin
        cfg_mem[{edit_set_q, cfg_flag}][7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        cfg_mem[{edit_set_q, cfg_flag}][15:8] <= dat_i[15:8];
      end
      if (sel_i[2]) begin
        cfg_mem[{edit_set_q, cfg_flag}][17:16] <= dat_i[17:16];
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      edit_set_q  <= `IOSD_RST_EDIT_SET;
      base_set_q  <= `IOSD_RST_SET;
      auto_en_q   <= 1'b0;
      trig_flag_q <= 3'h0;
      tgt_set_q   <= `IOSD_RST_SET;
    end else if (wr && sel_i[0] && idx == `IOSD_IDX_EDIT_SET) begin
      edit_set_q <= dat_i[2:0];
    end else if (wr && idx == `IOSD_IDX_SET_CTRL) begin
      if (sel_i[0]) begin
        base_set_q  <= dat_i[`IOSD_SC_BASE_MSB:`IOSD_SC_BASE_LSB];
        auto_en_q   <= dat_i[`IOSD_SC_AUTO_EN];
        trig_flag_q <= dat_i[`IOSD_SC_TRIG_MSB:`IOSD_SC_TRIG_LSB];
      end
      if (sel_i[1]) begin
        tgt_set_q <= dat_i[`IOSD_SC_TGT_MSB:`IOSD_SC_TGT_LSB];
      end
    end
  end

  // ==========================================
  // read mux; display registers have no write path at all
  always @* begin
    rd_d = 32'h0000_0000;
    if (cfg_hit) begin
      rd_d[`IOSD_CFG_W-1:0] = cfg_mem[{edit_set_q, cfg_flag}];
    end else begin
      case (idx)
        `IOSD_IDX_COND_MET:   rd_d[7:0]  = cond_q;
        `IOSD_IDX_FLAG_STAT:  rd_d[7:0]  = flag_q;
        `IOSD_IDX_TERM_STAT:  rd_d[7:0]  = term_q;
        `IOSD_IDX_ACTIVE_SET: rd_d[2:0]  = active_q;
        `IOSD_IDX_AIN_A_PRE:  rd_d[15:0] = ain_a_pre_q;
        `IOSD_IDX_AIN_A_POST: rd_d[15:0] = ain_a_post_q;
        `IOSD_IDX_AIN_B_PRE:  rd_d[15:0] = ain_b_pre_q;
        `IOSD_IDX_AIN_B_POST: rd_d[15:0] = ain_b_post_q;
        `IOSD_IDX_AOUT_A_PRE: rd_d[15:0] = aout_a_pre_q;
        `IOSD_IDX_EDIT_SET: begin
          rd_d[2:0]              = edit_set_q;
          rd_d[`IOSD_ES_BLOCKED] = edit_blocked;
        end
        `IOSD_IDX_SET_CTRL: begin
          rd_d[`IOSD_SC_BASE_MSB:`IOSD_SC_BASE_LSB] = base_set_q;
          rd_d[`IOSD_SC_AUTO_EN]                    = auto_en_q;
          rd_d[`IOSD_SC_TRIG_MSB:`IOSD_SC_TRIG_LSB] = trig_flag_q;
          rd_d[`IOSD_SC_TGT_MSB:`IOSD_SC_TGT_LSB]   = tgt_set_q;
        end
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // one-wait-state answer; every address is acked, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        dat_q <= rd_d; // [R14]
      end
    end
  end

endmodule

// file: testbench/iosd_chk.sv
// assertions on the io status bank bus and display ports
`timescale 1ns/1ps
module iosd_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  cond_met_i
);
  // ==========================================
  // bus and display relations
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire        rd_ack = ack_o && !we_i;
  wire [15:0] idx    = adr_i[17:2];
  a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_rdata_holds: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved outside ack");
  // needs three steady samples since the cond register adds a cycle
  a_cond_value: assert property (rd_ack && idx == 16'h2217 &&
    $past(cond_met_i, 1) == $past(cond_met_i, 3) && $past(cond_met_i, 2) == $past(cond_met_i, 3)
    |-> dat_o == {24'h000000, $past(cond_met_i, 2)}) else $error("cond display wrong");
  a_byte_width: assert property (rd_ack && idx >= 16'h2217 && idx <= 16'h2219
    |-> dat_o[31:8] == 24'h000000) else $error("status display too wide");
  a_set_range: assert property (rd_ack && idx == 16'h221A |-> dat_o[31:3] == 29'h0)
    else $error("active set out of range");
  a_pre_limit: assert property (rd_ack && (idx == 16'h221B || idx == 16'h221D)
    |-> dat_o[31:16] == 16'h0000 && $signed(dat_o[15:0]) >= -1000
    && $signed(dat_o[15:0]) <= 1000) else $error("pre gain display out of range");
  a_post_limit: assert property (rd_ack && (idx == 16'h221C || idx == 16'h221E
    || idx == 16'h2221) |-> dat_o[31:16] == 16'h0000 && $signed(dat_o[15:0]) >= -4000
    && $signed(dat_o[15:0]) <= 4000) else $error("post gain display out of range");
  c_write: cover property (ack_o && we_i);
  c_flags: cover property (rd_ack && idx == 16'h2218 && dat_o != 32'h0);
  c_auto: cover property (rd_ack && idx == 16'h221A && dat_o == 32'h3);
endmodule

bind iosd_status_bank iosd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .cond_met_i(cond_met_i));

// file: testbench/iosd_host.sv
// bus host model: classic wishbone single-cycle master
`timescale 1ns/1ps
module iosd_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o = 1'b0,
  output logic             stb_o = 1'b0,
  output logic             we_o  = 1'b0,
  output logic [17:0]      adr_o = 18'h00000,
  output logic [3:0]       sel_o = 4'h0,
  output logic [31:0]      dat_o = 32'h00000000
);
  // ==========================================
  // caller enters just after a rising edge; request held until ack is seen
  task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
                      output logic [31:0] q);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {i, 2'b00};
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released address and data lines do not keep the last value
    adr_o <= ~{i, 2'b00};
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// file: testbench/test_iosd_status_bank.sv
// self-checking bench for the io status display bank
`timescale 1ns/1ps
module test_iosd_status_bank;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  cond  = 8'h00;
  logic [15:0] a1p = 16'h0000, a1q = 16'h0000, a2p = 16'h0000, a2q = 16'h0000;
  logic [15:0] aop = 16'h0000;
  wire         cyc, stb, we, ack;
  wire  [17:0] adr;
  wire  [3:0]  sel;
  wire  [31:0] wd, rdat;
  wire  [7:0]  term;
  wire  [2:0]  act;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #4 clk_i = ~clk_i;
  iosd_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  iosd_status_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .cond_met_i(cond),
    .analog_input_one_pre_i(a1p), .analog_input_one_post_i(a1q),
    .analog_input_two_pre_i(a2p), .analog_input_two_post_i(a2q),
    .analog_output_one_pre_i(aop), .digital_output_one_o(term[0]),
    .digital_output_two_o(term[1]), .relay_one_o(term[2]), .relay_two_o(term[3]),
    .internal_output_a_o(term[4]), .internal_output_b_o(term[5]),
    .internal_output_c_o(term[6]), .internal_output_d_o(term[7]), .active_set_o(act));
  // ==========================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e, input string nm);
    u_host.xfer(1'b0, i, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    u_host.xfer(1'b1, i, d, q);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [15:0] ix [10] = '{16'h2217, 16'h2218, 16'h2219, 16'h221A, 16'h221B, 16'h221C,
                             16'h221D, 16'h221E, 16'h2221, 16'h2220};
    foreach (ix[k]) rd(ix[k], 32'h0, "reset value");
  endtask
  task automatic t_live;
    cond <= 8'hA5;
    a1p  <= 16'h05DC;
    a1q  <= 16'hEC78;
    a2p  <= 16'hFC18;
    a2q  <= 16'h0FA0;
    aop  <= 16'hF05F;
    repeat (3) @(posedge clk_i);
    wr(16'h2217, 32'h0000FFFF);
    rd(16'h2217, 32'hA5, "cond met");
    rd(16'h221B, 32'h03E8, "in one pre");
    rd(16'h221C, 32'hF060, "in one post");
    rd(16'h221D, 32'hFC18, "in two pre");
    rd(16'h221E, 32'h0FA0, "in two post");
    rd(16'h2221, 32'hF060, "out one pre");
  endtask
  task automatic t_sets;
    // edit set 1 while set 0 runs: flag 0 = or of cond 0,1; flag 2 = cond 2
    wr(16'h2300, 32'h10003);
    wr(16'h2302, 32'h00004);
    rd(16'h2218, 32'h0, "flags untouched");
    rd(16'h221A, 32'h0, "active set");
    wr(16'h2309, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(16'h2218, 32'h05, "flags set one");
    rd(16'h2219, 32'h05, "terminal reg");
    chk("terminal pins", {24'h0, term}, 32'h05);
    chk("active pin", {29'h0, act}, 32'h1);
    // same flag 0 in set 3, so the switch cannot oscillate
    wr(16'h2308, 32'h3);
    wr(16'h2300, 32'h10003);
    wr(16'h2309, 32'h309);
    repeat (4) @(posedge clk_i);
    rd(16'h221A, 32'h3, "auto switch");
    cond <= 8'h00;
    repeat (6) @(posedge clk_i);
    rd(16'h221A, 32'h1, "auto return");
  endtask
  task automatic t_logic;
    // set 1 runs: an edit aimed at it is dropped and flagged
    wr(16'h2308, 32'h1);
    rd(16'h2308, 32'h101, "edit blocked bit");
    wr(16'h2300, 32'h0);
    rd(16'h2300, 32'h10003, "blocked edit kept");
    // set 2 flag 1: and of inverted cond 0 and cond 7, result inverted
    wr(16'h2308, 32'h2);
    rd(16'h2308, 32'h2, "edit set free");
    wr(16'h2301, 32'h20181);
    wr(16'h2309, 32'h2);
    rd(16'h2308, 32'h102, "edit set now active");
    rd(16'h2309, 32'h2, "set control");
    rd(16'h2218, 32'h02, "inverted and idle");
    cond <= 8'h80;
    repeat (4) @(posedge clk_i);
    rd(16'h2218, 32'h0, "inverted and met");
    cond <= 8'h81;
    repeat (4) @(posedge clk_i);
    rd(16'h2217, 32'h81, "cond two met");
    rd(16'h2218, 32'h02, "inverted and broken");
    repeat (2) @(posedge clk_i);
    chk("terminal pins and", {24'h0, term}, 32'h02);
    chk("active pin two", {29'h0, act}, 32'h2);
  endtask
  task automatic t_rerst;
    // second reset in mid-run: active set and configs clear, edit set back to 1, displays keep tracking
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(16'h221A, 32'h0, "active after reset");
    rd(16'h2308, 32'h1, "edit set after reset");
    rd(16'h2301, 32'h0, "config after reset");
    rd(16'h221B, 32'h03E8, "live after reset");
    rd(16'h2217, 32'h81, "cond after reset");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_live();
    t_sets();
    t_logic();
    t_rerst();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
endmodule
